// ---- design/lit_mul_pkg.sv ----
/*
 * Constants for the literal/move/multiply decode and execute block.
 * Assumes a core clock where one instruction cycle is four quarter-cycles.
 */
// Behaviour
// - Literal load writes accumulator, flags untouched
// - Store copies accumulator to addressed file register
// - Eight-bit file address spans one bank
// - Access bit zero selects access bank
// - Access bit one uses bank select register
// - Extended set, access bank, low address: indexed
// - Literal multiply writes unsigned product high/low
// - Literal multiply keeps accumulator and flags
// - Multiply raises no overflow, carry or zero
// - File multiply forms product, operands unchanged
package lit_mul_pkg;
    localparam logic [7:0] OP_LOAD_LIT = 8'h0e;
    localparam logic [7:0] OP_MUL_LIT = 8'h0d;
    localparam logic [6:0] OP_STORE_FILE = 7'h37;
    localparam logic [6:0] OP_MUL_FILE = 7'h01;
    localparam logic [7:0] INDEXED_MAX = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam int ADDR_W = 12;
    localparam int SP_ACCESS_A = 0;
    typedef enum logic [1:0] {Q1, Q2, Q3, Q4} quarter_t;
    typedef enum logic [1:0] {K_NONE, K_LOAD, K_STORE, K_MUL} kind_t;
endpackage : lit_mul_pkg

// ---- design/literal_move_multiply_exec.sv ----
/*
 * Decode and execute of literal load, accumulator store and the two multiplies.
 * Assumes program memory holds instr_in stable through Q1, while fetch_out is high,
 * and that the data memory returns file_rdata_in during the same Q2 in which
 * file_addr_out is presented.
 * One instruction takes four clocks, one per quarter:
 *   Q1 decode and address resolution, Q2 file read,
 *   Q3 product and store data, Q4 result write.
 * Status flags live elsewhere; nothing here touches them.
 * Unknown opcodes pass through one instruction cycle as no-ops.
 */
`timescale 1ns/1ns
module literal_move_multiply_exec #(
    parameter int DATA_W = 8
) (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [15:0] instr_in,
    input wire logic ext_set_en_in,
    input wire logic [3:0] bank_select_reg_in,
    input wire logic [11:0] index_base_in,
    input wire logic [DATA_W-1:0] file_rdata_in,
    output logic fetch_out,
    output logic [11:0] file_addr_out,
    output logic file_rd_out,
    output logic file_wr_out,
    output logic [DATA_W-1:0] file_wdata_out,
    output logic [DATA_W-1:0] working_accumulator_out,
    output logic [DATA_W-1:0] product_high_byte_out,
    output logic [DATA_W-1:0] product_low_byte_out
);
    // -------------------------------------------------------------------
    // State
    // -------------------------------------------------------------------
    // All state of the block, registered as one word
    typedef struct packed {
        lit_mul_pkg::quarter_t q;
        lit_mul_pkg::kind_t kind;
        logic [lit_mul_pkg::ADDR_W-1:0] addr;
        logic [DATA_W-1:0] opnd;
        logic [2*DATA_W-1:0] prod;
        logic [DATA_W-1:0] acc;
        logic [DATA_W-1:0] ph;
        logic [DATA_W-1:0] pl;
        logic rd;
        logic wr;
        logic [DATA_W-1:0] wdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    // -------------------------------------------------------------------
    // Address resolution
    // -------------------------------------------------------------------
    // True when an access-bank operand falls in the indexed window
    function automatic logic in_indexed_window(input logic a, input logic ext, input logic [7:0] f);
        logic hit;
        hit = 1'b0;
        if (!a && ext && (f <= lit_mul_pkg::INDEXED_MAX)) begin
            hit = 1'b1;
        end
        return hit;
    endfunction : in_indexed_window

    // Indexed literal offset address: base plus the 8-bit offset
    function automatic logic [11:0] indexed_addr(input logic [11:0] base, input logic [7:0] f);
        logic [11:0] r;
        r = 12'(base + {4'h0, f});
        return r;
    endfunction : indexed_addr

    // Access bank: bank zero below the split, top bank from the split up
    function automatic logic [11:0] access_addr(input logic [7:0] f);
        logic [11:0] r;
        if (f < lit_mul_pkg::ACCESS_SPLIT) begin
            r = {lit_mul_pkg::ACCESS_LO_BANK, f};
        end else begin
            r = {lit_mul_pkg::ACCESS_HI_BANK, f};
        end
        return r;
    endfunction : access_addr

    // Banked access: the bank number supplies the upper address bits
    function automatic logic [11:0] banked_addr(input logic [3:0] bank, input logic [7:0] f);
        logic [11:0] r;
        r = {bank, f};
        return r;
    endfunction : banked_addr

    // Resolves a file operand to a full data address
    function automatic logic [11:0] resolve_addr(input logic a, input logic [7:0] f,
                                                 input logic ext, input logic [3:0] bank,
                                                 input logic [11:0] base);
        logic [11:0] r;
        if (a) begin
            r = banked_addr(bank, f);
        end else if (in_indexed_window(a, ext, f)) begin
            r = indexed_addr(base, f);
        end else begin
            r = access_addr(f);
        end
        return r;
    endfunction : resolve_addr

    // -------------------------------------------------------------------
    // Opcode decode
    // -------------------------------------------------------------------
    // File multiply is the only one of these that reads a file register
    function automatic logic is_file_mul(input logic [15:0] w);
        logic hit;
        hit = (w[15:9] == lit_mul_pkg::OP_MUL_FILE);
        return hit;
    endfunction : is_file_mul

    // Maps an instruction word to the work it does
    function automatic lit_mul_pkg::kind_t decode_kind(input logic [15:0] w);
        lit_mul_pkg::kind_t k;
        k = lit_mul_pkg::K_NONE;
        if (w[15:8] == lit_mul_pkg::OP_LOAD_LIT) begin
            k = lit_mul_pkg::K_LOAD;
        end else if (w[15:8] == lit_mul_pkg::OP_MUL_LIT) begin
            k = lit_mul_pkg::K_MUL;
        end else if (w[15:9] == lit_mul_pkg::OP_STORE_FILE) begin
            k = lit_mul_pkg::K_STORE;
        end else if (is_file_mul(w)) begin
            k = lit_mul_pkg::K_MUL;
        end
        // Unknown words fall through as no-ops
        return k;
    endfunction : decode_kind

    // Unsigned full-width product; no carry, overflow or zero flag exists
    function automatic logic [2*DATA_W-1:0] full_product(input logic [DATA_W-1:0] x,
                                                         input logic [DATA_W-1:0] y);
        logic [2*DATA_W-1:0] p;
        p = (2*DATA_W)'(x) * (2*DATA_W)'(y);
        return p;
    endfunction : full_product

    // -------------------------------------------------------------------
    // Quarter-cycle sequencing
    // -------------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        next_cur.rd = 1'b0;
        next_cur.wr = 1'b0;
        case (cur.q)
            // Decode the word and resolve its file address
            lit_mul_pkg::Q1: begin
                next_cur.q = lit_mul_pkg::Q2;
                next_cur.opnd = instr_in[7:0];
                next_cur.addr = resolve_addr(instr_in[8], instr_in[7:0], ext_set_en_in,
                                             bank_select_reg_in, index_base_in);
                next_cur.kind = decode_kind(instr_in);
                next_cur.rd = is_file_mul(instr_in);
            end
            // Capture the file operand; literals keep the value taken in Q1
            lit_mul_pkg::Q2: begin
                next_cur.q = lit_mul_pkg::Q3;
                if (cur.rd) begin
                    next_cur.opnd = file_rdata_in;
                end
            end
            // Form the product and present the store data
            lit_mul_pkg::Q3: begin
                next_cur.q = lit_mul_pkg::Q4;
                next_cur.prod = full_product(cur.acc, cur.opnd);
                if (cur.kind == lit_mul_pkg::K_STORE) begin
                    next_cur.wr = 1'b1;
                    next_cur.wdata = cur.acc;
                end
            end
            // Write back and return to decode
            lit_mul_pkg::Q4: begin
                next_cur.q = lit_mul_pkg::Q1;
                case (cur.kind)
                    lit_mul_pkg::K_LOAD: begin
                        next_cur.acc = cur.opnd;
                    end
                    lit_mul_pkg::K_MUL: begin
                        next_cur.ph = cur.prod[2*DATA_W-1:DATA_W];
                        next_cur.pl = cur.prod[DATA_W-1:0];
                    end
                    default: begin
                        // Store and no-op leave the results alone
                    end
                endcase
            end
            default: begin
                next_cur.q = lit_mul_pkg::Q1;
            end
        endcase
    end

    // -------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------
    // Synchronous reset puts the sequencer in Q1 with all results zero
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    // -------------------------------------------------------------------
    // Outputs
    // -------------------------------------------------------------------
    // Every output but fetch_out is a plain view of a registered field; fetch_out decodes Q1 from cur.q
    assign fetch_out = (cur.q == lit_mul_pkg::Q1);
    assign file_addr_out = cur.addr;
    assign file_rd_out = cur.rd;
    assign file_wr_out = cur.wr;
    assign file_wdata_out = cur.wdata;
    assign working_accumulator_out = cur.acc;
    assign product_high_byte_out = cur.ph;
    assign product_low_byte_out = cur.pl;
endmodule : literal_move_multiply_exec

// ---- testbench/lit_mul_checker.sv ----
/* Port assertions for the decode/execute block; bound in at the foot. */
`timescale 1ns/1ns
module lit_mul_checker (
    input wire logic mclk_in, nrst_in, fetch_out, file_rd_out, file_wr_out,
    input wire logic [15:0] instr_in,
    input wire logic [7:0] file_rdata_in, file_wdata_out, working_accumulator_out,
    input wire logic [7:0] product_high_byte_out, product_low_byte_out
);
    wire logic [7:0] acc = working_accumulator_out;
    wire logic [7:0] k = instr_in[7:0];
    wire logic [15:0] prod = {product_high_byte_out, product_low_byte_out};
    wire logic [15:0] lp = 16'(acc) * k;
    wire logic [15:0] fp = 16'(acc) * file_rdata_in;
    wire logic ld = fetch_out && instr_in[15:8] == 8'h0e;
    wire logic ml = fetch_out && instr_in[15:8] == 8'h0d;
    wire logic st = fetch_out && instr_in[15:9] == 7'h37;
    wire logic mf = fetch_out && instr_in[15:9] == 7'h01;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!nrst_in);
    property p_cyc; fetch_out |=> !fetch_out [*3] ##1 fetch_out; endproperty
    a_cyc: assert property (p_cyc) else $error("cadence");
    property p_ld; ld |-> ##4 acc == $past(k, 4); endproperty
    a_ld: assert property (p_ld) else $error("load");
    property p_ml; ml |-> ##4 prod == $past(lp, 4); endproperty
    a_ml: assert property (p_ml) else $error("mul lit");
    property p_keep; ml |=> $stable(acc) [*4]; endproperty
    a_keep: assert property (p_keep) else $error("acc moved");
    property p_st; st |-> ##3 file_wr_out && file_wdata_out == $past(acc, 3); endproperty
    a_st: assert property (p_st) else $error("store");
    property p_wr; file_wr_out |-> $past(st, 3) ##1 !file_wr_out; endproperty
    a_wr: assert property (p_wr) else $error("write");
    property p_mf; mf |=> file_rd_out ##3 prod == $past(fp, 3) && $stable(acc); endproperty
    a_mf: assert property (p_mf) else $error("mul file");
    property p_rd; file_rd_out |-> $past(mf); endproperty
    a_rd: assert property (p_rd) else $error("read");
    cover property (ld);
    cover property (st ##3 file_wr_out);
    cover property (mf ##1 file_rd_out);
endmodule : lit_mul_checker
bind literal_move_multiply_exec lit_mul_checker u_chk (.*);

// ---- testbench/literal_move_multiply_exec_tb.sv ----
/* Bench: random program from prog_mem; a model checks each result. */
`timescale 1ns/1ns
module literal_move_multiply_exec_tb;
    logic mclk_in = 1'h0, nrst_in = 1'h0, ext_set_en_in = 1'h0, fetch_out, file_rd_out, file_wr_out;
    logic [3:0] bank_select_reg_in = 4'h0;
    logic [11:0] index_base_in = 12'h000, file_addr_out, ea;
    logic [7:0] file_rdata_in = 8'h00, file_wdata_out, working_accumulator_out, f, acc = 8'h00;
    logic [7:0] product_high_byte_out, product_low_byte_out, ops [7] = '{8'h0e, 8'h0d, 8'h6e, 8'h6f, 8'h02, 8'h03, 8'hff};
    logic [15:0] instr_in, ins, prod = 16'h0000;
    int failures = 0, check_count = 0;
    literal_move_multiply_exec dut (.*);
    prog_mem pm (.mclk_in, .nrst_in, .fetch_in(fetch_out), .word_out(instr_in));
    initial forever #2 mclk_in = ~mclk_in;
    task chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task end_of_test;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(32'hcff4));
        for (int i = 0; i < 64; i++) pm.mem[i] = {ops[i % 7], i < 7 ? 8'h5f : i < 14 ? 8'h60 : 8'($urandom)};
        repeat (20) @(posedge mclk_in);
        nrst_in <= 1'h1;
        @(negedge mclk_in);
        for (int n = 0; n < 56; n++) begin
            ins = instr_in;
            f = ins[7:0];
            ea = ins[8] ? {bank_select_reg_in, f} : ext_set_en_in && f <= 8'h5f ? index_base_in + 12'(f)
                : {f < 8'h60 ? 4'h0 : 4'hf, f};
            @(posedge mclk_in) file_rdata_in <= 8'($urandom);
            @(negedge mclk_in) chk(16'(file_rd_out), 16'(ins[15:9] == 7'h01));
            if (ins[15:9] == 7'h01 || ins[15:9] == 7'h37) chk(16'(file_addr_out), 16'(ea));
            if (ins[15:9] == 7'h01) prod = 16'(acc) * file_rdata_in;
            if (ins[15:8] == 8'h0d) prod = 16'(acc) * f;
            repeat (2) @(negedge mclk_in);
            chk(16'(file_wr_out), 16'(ins[15:9] == 7'h37));
            if (ins[15:9] == 7'h37) chk(16'(file_wdata_out), 16'(acc));
            if (ins[15:8] == 8'h0e) acc = f;
            @(posedge mclk_in);
            ext_set_en_in <= 1'($urandom);
            bank_select_reg_in <= 4'($urandom);
            index_base_in <= 12'($urandom);
            @(negedge mclk_in) chk(16'(working_accumulator_out), 16'(acc));
            chk({product_high_byte_out, product_low_byte_out}, prod);
        end
        end_of_test;
    end
    initial begin
        #1500;
        failures++;
        end_of_test;
    end
endmodule : literal_move_multiply_exec_tb

// ---- testbench/prog_mem.sv ----
/* Program memory: one word per instruction, advancing on each fetch. */
`timescale 1ns/1ns
module prog_mem (
    input wire logic mclk_in, nrst_in, fetch_in,
    output logic [15:0] word_out
);
    logic [15:0] mem [64];
    logic [5:0] pc;
    assign word_out = mem[pc];
    always_ff @(posedge mclk_in) begin
        if (!nrst_in) pc <= 6'h00;
        else if (fetch_in) pc <= pc + 6'h01;
    end
endmodule : prog_mem
